/* File: src/osq_sequencer.sv */
// Sampling sequencer: registers, slow clock, triggers, slot control
`timescale 1ns/1ps
`include "osq_regs.svh"

module osq_sequencer
    import osq_pkg::*;
#(
    parameter int CONV_W = 14
)(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    input  wire logic [7:0]        regAddr,
    input  wire logic [15:0]       regWdata,
    output logic      [15:0]       regRdata,
    input  wire logic              intPinIn,
    input  wire logic              pdsoPinIn,
    output logic                   intBufEn,
    output logic                   pdsoBufEn,
    output osq_diodes_t            diodeConnect,
    output logic                   slotAActive,
    output logic                   slotBActive,
    output logic                   pulseReq,
    input  wire logic              adcValid,
    input  wire logic [CONV_W-1:0] adcData,
    output logic      [26:0]       dataA,
    output logic                   dataAValid,
    output logic      [26:0]       dataB,
    output logic                   dataBValid
);

    localparam int SLEEP_MIN = `OSQ_SLEEP_MIN_TICKS;

    generate
        if (SLEEP_MIN > 255) begin : g_bad_sleep
            $error("sleep count too large");
        end
    endgenerate

    osq_seq_t sReg;
    osq_seq_t sNext;
    logic     doneA;
    logic     doneB;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Unknown codes fall back to floating so a bad value never
    // loads the front end with an unintended diode group
    function automatic osq_diodes_t decodeSel(input logic [3:0] c);
        osq_diodes_t d;
        unique case (c)
            4'h1:    d = '{high: 1'b1, low: 1'b1};
            4'h4:    d = '{high: 1'b1, low: 1'b0};
            4'h5:    d = '{high: 1'b0, low: 1'b1};
            default: d = '0;
        endcase
        return d;
    endfunction

    function automatic logic [15:0] readMux(input osq_seq_t s,
                                            input logic [7:0] a);
        logic [15:0] v;
        unique case (a)
            `OSQ_ADDR_MODE:      v = {14'h0000, s.modeReg};
            `OSQ_ADDR_RATE:      v = s.rateReg;
            `OSQ_ADDR_SWITCH:    v = s.switchReg;
            `OSQ_ADDR_AVG:       v = s.avgReg;
            `OSQ_ADDR_PULSE_A:   v = s.pulseAReg;
            `OSQ_ADDR_PULSE_B:   v = s.pulseBReg;
            `OSQ_ADDR_SLOTB_CTL: v = s.slotBCtlReg;
            `OSQ_ADDR_CLK_TUNE:  v = s.clkTuneReg;
            `OSQ_ADDR_PIN_CFG:   v = s.pinCfgReg;
            default:             v = 16'h0000;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] divLimit;
        logic        extClk;
        logic        pdsoRise;
        logic        intRise;
        logic        syncEdge;
        logic        extTrig;
        logic        sleepOk;
        logic        startNow;
        logic [7:0]  nA;
        logic [7:0]  nB;
        logic [7:0]  nCur;
        logic        lastPulse;
        divLimit  = 16'(`OSQ_SLOW_DIV - `OSQ_TRIM_CENTER - 1)
                  + {10'h000, sReg.clkTuneReg[`OSQ_TRIM_MSB:`OSQ_TRIM_LSB]};
        extClk    = 1'b0;
        // a pin reads as low unless its input buffer is on
        pdsoRise  = sReg.pdsoSync[1] & ~sReg.pdsoSync[2]
                  & sReg.pinCfgReg[`OSQ_POWER_DOWN_STATUS_PIN_BUF_BIT];
        intRise   = sReg.intSync[1] & ~sReg.intSync[2]
                  & sReg.pinCfgReg[`OSQ_INT_BUF_BIT];
        syncEdge  = 1'b0;
        extTrig   = sReg.slotBCtlReg[`OSQ_EXT_TRIG_BIT];
        sleepOk   = sReg.sleepCnt >= 8'(SLEEP_MIN);
        startNow  = 1'b0;
        nA        = sReg.pulseAReg[`OSQ_PULSE_MSB:`OSQ_PULSE_LSB];
        nB        = sReg.pulseBReg[`OSQ_PULSE_MSB:`OSQ_PULSE_LSB];
        nCur      = (sReg.state == OSQ_ST_SLOTA) ? nA : nB;
        lastPulse = (sReg.pulseCnt + 8'h01) == nCur;
        doneA     = 1'b0;
        doneB     = 1'b0;
        sNext     = sReg;
        sNext.pulseReq = 1'b0;

        // Register writes
        if (regWrite) begin
            unique case (regAddr)
                `OSQ_ADDR_MODE:      sNext.modeReg = regWdata[`OSQ_MODE_MSB:0];
                `OSQ_ADDR_RATE:      sNext.rateReg     = regWdata;
                `OSQ_ADDR_SWITCH:    sNext.switchReg   = regWdata;
                `OSQ_ADDR_AVG:       sNext.avgReg      = regWdata;
                `OSQ_ADDR_PULSE_A:   sNext.pulseAReg   = regWdata;
                `OSQ_ADDR_PULSE_B:   sNext.pulseBReg   = regWdata;
                `OSQ_ADDR_SLOTB_CTL: sNext.slotBCtlReg = regWdata;
                `OSQ_ADDR_CLK_TUNE:  sNext.clkTuneReg  = regWdata;
                `OSQ_ADDR_PIN_CFG:   sNext.pinCfgReg   = regWdata;
                default:             sNext.modeReg     = sReg.modeReg;
            endcase
        end
        if (regRead) begin
            sNext.rdata = readMux(sReg, regAddr);
        end

        // Pin synchronisers; stage 0 feeds only stage 1
        sNext.intSync  = {sReg.intSync[1:0], intPinIn};
        sNext.pdsoSync = {sReg.pdsoSync[1:0], pdsoPinIn};

        // enable plus bypass uses status pin ticks
        extClk = sReg.clkTuneReg[`OSQ_CLK_EN_BIT]
               & sReg.clkTuneReg[`OSQ_CLK_BYP_BIT];
        // internal divider makes the slow tick
        if (extClk) begin
            sNext.tick   = pdsoRise;
            sNext.divCnt = '0;
        end else if (sReg.divCnt >= divLimit) begin
            sNext.tick   = 1'b1;
            sNext.divCnt = '0;
        end else begin
            sNext.tick   = 1'b0;
            sNext.divCnt = sReg.divCnt + 16'h0001;
        end

        // rising edge on the chosen sync source
        unique case (sReg.pinCfgReg[`OSQ_SYNC_SEL_MSB:`OSQ_SYNC_SEL_LSB])
            `OSQ_SYNC_INT:  syncEdge = intRise;
            `OSQ_SYNC_POWER_DOWN_STATUS_PIN: syncEdge = pdsoRise;
            default:        syncEdge = 1'b0;
        endcase

        // Counters advance on slow ticks
        if (sReg.tick) begin
            sNext.periodCnt = sReg.periodCnt + 16'h0001;
            if (!sleepOk) begin
                sNext.sleepCnt = sReg.sleepCnt + 8'h01;
            end
        end

        // the mode field steers the sequencer
        if (osq_mode_t'(sReg.modeReg) != OSQ_MODE_NORMAL) begin
            sNext.state    = OSQ_ST_IDLE;
            sNext.syncPend = 1'b0;
            sNext.waitConv = 1'b0;
        end else begin
            unique case (sReg.state)
                OSQ_ST_IDLE: begin
                    sNext.state     = OSQ_ST_SLEEP;
                    sNext.periodCnt = '0;
                    sNext.sleepCnt  = '0;
                end
                OSQ_ST_SLEEP: begin
                    // external edges replace the period timer
                    if (extTrig) begin
                        if (syncEdge) begin
                            sNext.state      = OSQ_ST_DELAY;
                            sNext.delayTicks = '0;
                        end
                    end else if (sReg.tick && sleepOk
                                 && sNext.periodCnt >= sReg.rateReg) begin
                        startNow = 1'b1;
                    end
                end
                OSQ_ST_DELAY: begin
                    // second tick after the edge ends the wait
                    if (sReg.tick && sReg.delayTicks != 2'h2) begin
                        sNext.delayTicks = sReg.delayTicks + 2'h1;
                    end
                    if (sReg.delayTicks == 2'h2 && sleepOk) begin
                        startNow = 1'b1;
                    end
                end
                OSQ_ST_SLOTA, OSQ_ST_SLOTB: begin
                    if (!sReg.waitConv) begin
                        sNext.pulseReq = 1'b1;
                        sNext.waitConv = 1'b1;
                    end else if (adcValid) begin
                        sNext.waitConv = 1'b0;
                        sNext.pulseCnt = sReg.pulseCnt + 8'h01;
                        if (lastPulse) begin
                            sNext.pulseCnt = '0;
                            sNext.sleepCnt = '0;
                            // slot A hands over to slot B, or to sleep when slot B's pulse count is zero
                            if (sReg.state == OSQ_ST_SLOTA) begin
                                doneA = 1'b1;
                                sNext.state = (nB != 8'h00)
                                            ? OSQ_ST_SLOTB : OSQ_ST_SLEEP;
                            end else begin
                                doneB = 1'b1;
                                sNext.state = OSQ_ST_SLEEP;
                            end
                        end
                    end
                end
            endcase
        end

        // Period start: skip a slot whose pulse count is zero
        if (startNow) begin
            sNext.periodCnt = '0;
            sNext.pulseCnt  = '0;
            sNext.waitConv  = 1'b0;
            sNext.state     = (nA != 8'h00) ? OSQ_ST_SLOTA
                            : (nB != 8'h00) ? OSQ_ST_SLOTB : OSQ_ST_SLEEP;
        end

        unique case (sNext.state)
            OSQ_ST_SLOTA: sNext.diodes = decodeSel(
                sReg.switchReg[`OSQ_SEL_A_MSB:`OSQ_SEL_A_LSB]);
            OSQ_ST_SLOTB: sNext.diodes = decodeSel(
                sReg.switchReg[`OSQ_SEL_B_MSB:`OSQ_SEL_B_LSB]);
            default:      sNext.diodes = '0;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sReg             <= '0;
            sReg.state       <= OSQ_ST_IDLE;
            sReg.rateReg     <= `OSQ_RST_RATE;
            sReg.pulseAReg   <= `OSQ_RST_PULSE;
            sReg.pulseBReg   <= `OSQ_RST_PULSE;
            sReg.clkTuneReg  <= `OSQ_RST_CLK_TUNE;
        end else begin
            sReg <= sNext;
        end
    end

    // ------------------------------------------------------------
    // Per-slot accumulators
    // ------------------------------------------------------------
    osq_accum #(.CONV_W(CONV_W)) uAccA (
        .clk        (clk),
        .rst        (rst),
        .flush      (sReg.state == OSQ_ST_IDLE),
        .convValid  (adcValid & sReg.waitConv
                     & (sReg.state == OSQ_ST_SLOTA)),
        .convData   (adcData),
        .sampleDone (doneA),
        .avgLog2    (sReg.avgReg[`OSQ_AVG_A_MSB:`OSQ_AVG_A_LSB]),
        .outData    (dataA),
        .outValid   (dataAValid)
    );

    osq_accum #(.CONV_W(CONV_W)) uAccB (
        .clk        (clk),
        .rst        (rst),
        .flush      (sReg.state == OSQ_ST_IDLE),
        .convValid  (adcValid & sReg.waitConv
                     & (sReg.state == OSQ_ST_SLOTB)),
        .convData   (adcData),
        .sampleDone (doneB),
        .avgLog2    (sReg.avgReg[`OSQ_AVG_B_MSB:`OSQ_AVG_B_LSB]),
        .outData    (dataB),
        .outValid   (dataBValid)
    );

    // Outputs straight from state flops
    assign regRdata     = sReg.rdata;
    assign intBufEn     = sReg.pinCfgReg[`OSQ_INT_BUF_BIT];
    assign pdsoBufEn    = sReg.pinCfgReg[`OSQ_POWER_DOWN_STATUS_PIN_BUF_BIT];
    assign diodeConnect = sReg.diodes;
    assign slotAActive  = sReg.state == OSQ_ST_SLOTA;
    assign slotBActive  = sReg.state == OSQ_ST_SLOTB;
    assign pulseReq     = sReg.pulseReq;

endmodule

/* File: pkg/osq_regs.svh */
// Register map and timing macros
`ifndef OSQ_REGS_SVH
`define OSQ_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OSQ_ADDR_MODE      8'h10
`define OSQ_ADDR_RATE      8'h12
`define OSQ_ADDR_SWITCH    8'h14
`define OSQ_ADDR_AVG       8'h15
`define OSQ_ADDR_PULSE_A   8'h31
`define OSQ_ADDR_PULSE_B   8'h36
`define OSQ_ADDR_SLOTB_CTL 8'h38
`define OSQ_ADDR_CLK_TUNE  8'h4b
`define OSQ_ADDR_PIN_CFG   8'h4f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OSQ_MODE_MSB       1
`define OSQ_SEL_B_MSB      11
`define OSQ_SEL_B_LSB      8
`define OSQ_SEL_A_MSB      7
`define OSQ_SEL_A_LSB      4
`define OSQ_AVG_A_MSB      2
`define OSQ_AVG_A_LSB      0
`define OSQ_AVG_B_MSB      6
`define OSQ_AVG_B_LSB      4
`define OSQ_PULSE_MSB      15
`define OSQ_PULSE_LSB      8
`define OSQ_EXT_TRIG_BIT   14
`define OSQ_TRIM_MSB       5
`define OSQ_TRIM_LSB       0
`define OSQ_CLK_EN_BIT     7
`define OSQ_CLK_BYP_BIT    8
`define OSQ_SYNC_SEL_MSB   3
`define OSQ_SYNC_SEL_LSB   2
`define OSQ_INT_BUF_BIT    1
`define OSQ_POWER_DOWN_STATUS_PIN_BUF_BIT   5

// Sync source codes
`define OSQ_SYNC_INT       2'h1
`define OSQ_SYNC_POWER_DOWN_STATUS_PIN      2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OSQ_RST_RATE       16'h0020
`define OSQ_RST_PULSE      16'h0100
`define OSQ_RST_CLK_TUNE   16'h2612

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OSQ_CLK_HZ         100000000
`define OSQ_SLOW_HZ        32000
`define OSQ_TSLEEP_US      222
`define OSQ_SLOW_DIV       (`OSQ_CLK_HZ / `OSQ_SLOW_HZ)
`define OSQ_TRIM_CENTER    32
`define OSQ_SLEEP_MIN_TICKS \
    ((`OSQ_TSLEEP_US * `OSQ_SLOW_HZ + 999999) / 1000000)

`endif

/* File: pkg/osq_pkg.sv */
// Types for the sample sequencer
package osq_pkg;

    // ------------------------------------------------------------
    // Operating modes and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OSQ_MODE_STANDBY = 2'h0,
        OSQ_MODE_PROGRAM = 2'h1,
        OSQ_MODE_NORMAL  = 2'h2
    } osq_mode_t;

    typedef enum logic [4:0] {
        OSQ_ST_IDLE  = 5'h01,
        OSQ_ST_SLEEP = 5'h02,
        OSQ_ST_DELAY = 5'h04,
        OSQ_ST_SLOTA = 5'h08,
        OSQ_ST_SLOTB = 5'h10
    } osq_state_t;

    // ------------------------------------------------------------
    // Photodiode group connection: low = inputs 1-4, high = 5-8
    // ------------------------------------------------------------
    typedef struct packed {
        logic high;
        logic low;
    } osq_diodes_t;

    // Accumulator state
    typedef struct packed {
        logic [19:0] sampleSum;
        logic [26:0] avgSum;
        logic [6:0]  avgCnt;
        logic [26:0] outData;
        logic        outValid;
    } osq_acc_t;

    // Sequencer state
    typedef struct packed {
        logic [1:0]  modeReg;
        logic [15:0] rateReg;
        logic [15:0] switchReg;
        logic [15:0] avgReg;
        logic [15:0] pulseAReg;
        logic [15:0] pulseBReg;
        logic [15:0] slotBCtlReg;
        logic [15:0] clkTuneReg;
        logic [15:0] pinCfgReg;
        logic [15:0] rdata;
        osq_state_t  state;
        logic [15:0] divCnt;
        logic        tick;
        logic [2:0]  intSync;
        logic [2:0]  pdsoSync;
        logic [15:0] periodCnt;
        logic [7:0]  sleepCnt;
        logic [1:0]  delayTicks;
        logic        syncPend;
        logic [7:0]  pulseCnt;
        logic        waitConv;
        logic        pulseReq;
        osq_diodes_t diodes;
    } osq_seq_t;

endpackage

/* File: src/osq_accum.sv */
// Per-slot pulse accumulator and inter-sample averager
`timescale 1ns/1ps
`include "osq_regs.svh"

module osq_accum
    import osq_pkg::*;
#(
    parameter int CONV_W = 14
)(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              flush,
    input  wire logic              convValid,
    input  wire logic [CONV_W-1:0] convData,
    input  wire logic              sampleDone,
    input  wire logic [2:0]        avgLog2,
    output logic      [26:0]       outData,
    output logic                   outValid
);

    generate
        if (CONV_W < 1 || CONV_W > 20) begin : g_bad_width
            $error("CONV_W out of range");
        end
    endgenerate

    osq_acc_t accReg;
    osq_acc_t accNext;

    // ------------------------------------------------------------
    // Accumulation
    // ------------------------------------------------------------
    always_comb begin
        logic [20:0] wide;
        logic [19:0] clipped;
        logic [19:0] sampleNow;
        logic [26:0] total;
        logic [6:0]  lastCnt;
        wide    = {1'b0, accReg.sampleSum} + 21'(convData);
        clipped = wide[20] ? 20'hfffff : wide[19:0];
        // Last conversion of a slot arrives together with done
        sampleNow = convValid ? clipped : accReg.sampleSum;
        total   = accReg.avgSum + 27'(sampleNow);
        lastCnt = 7'((8'h01 << avgLog2) - 8'h01);
        accNext = accReg;
        accNext.outValid = 1'b0;
        if (flush) begin
            accNext.sampleSum = '0;
            accNext.avgSum    = '0;
            accNext.avgCnt    = '0;
        end else if (sampleDone) begin
            // every Nth sample the N-sample sum is published
            if (accReg.avgCnt == lastCnt) begin
                accNext.outData  = total;
                accNext.outValid = 1'b1;
                accNext.avgSum   = '0;
                accNext.avgCnt   = '0;
            end else begin
                accNext.avgSum = total;
                accNext.avgCnt = accReg.avgCnt + 7'h01;
            end
            accNext.sampleSum = '0;
        end else if (convValid) begin
            // each conversion adds into the running sum
            // sum clips at the 20-bit ceiling
            accNext.sampleSum = clipped;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accReg <= '0;
        end else begin
            accReg <= accNext;
        end
    end

    assign outData  = accReg.outData;
    assign outValid = accReg.outValid;

endmodule

/* File: testbench/osq_adc_model.sv */
// Converter stand-in answering pulse requests
`timescale 1ns/1ps
module osq_adc_model
    import osq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [3:0]  lag,
    input  wire logic        pulseReq,
    output logic             adcValid,
    output logic      [13:0] adcData
);
    // ------------------------------------------------------------
    // Conversion answer
    // ------------------------------------------------------------
    initial begin
        adcValid = 1'b0;
        adcData  = 14'h0000;
    end
    // one 14-bit result per pulse
    // Idle data flips every cycle so a stale value never sums by luck
    always @(posedge clk) begin
        if (pulseReq) begin
            repeat (lag) @(posedge clk);
            adcValid <= 1'b1;
            adcData  <= 14'($urandom);
        end else begin
            adcValid <= 1'b0;
            adcData  <= ~adcData;
        end
    end
endmodule

/* File: testbench/osq_seq_sva.sv */
// Port assertions for the sample sequencer
`timescale 1ns/1ps
module osq_seq_sva
    import osq_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    input wire logic        intBufEn,
    input wire logic        pdsoBufEn,
    input wire osq_diodes_t diodeConnect,
    input wire logic        slotAActive,
    input wire logic        slotBActive,
    input wire logic        pulseReq
);
    // ------------------------------------------------------------
    // Write mirrors
    // ------------------------------------------------------------
    logic [15:0] sw_reg;
    logic [1:0]  mode_reg;
    // Mirrors avoid design internals
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_reg   <= 16'h0000;
            mode_reg <= 2'h0;
        end else if (regWrite && regAddr == 8'h14) begin
            sw_reg <= regWdata;
        end else if (regWrite && regAddr == 8'h10) begin
            mode_reg <= regWdata[1:0];
        end
    end
    function automatic logic [1:0] dec(input logic [3:0] c);
        return c == 4'h1 ? 2'h3 : c == 4'h4 ? 2'h2 : c == 4'h5 ? 2'h1 : 2'h0;
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence swRead;
        regRead && regAddr == 8'h14;
    endsequence
    sequence notNormal;
        (mode_reg != 2'h2) [*2];
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_pulse_single: assert property (pulseReq |=> !pulseReq)
        else $error("long pulse");
    a_pulse_in_slot: assert property (pulseReq |-> slotAActive || slotBActive)
        else $error("pulse outside slot");
    a_slot_exclusive: assert property (!(slotAActive && slotBActive))
        else $error("both slots active");
    a_diode_slot_a: assert property (slotAActive |-> diodeConnect == dec(sw_reg[7:4]))
        else $error("slot A diodes");
    a_diode_slot_b: assert property (slotBActive |-> diodeConnect == dec(sw_reg[11:8]))
        else $error("slot B diodes");
    a_buf_enable: assert property (regWrite && regAddr == 8'h4f |=>
        16'({pdsoBufEn, 3'h0, intBufEn, 1'b0}) == ($past(regWdata) & 16'h0022))
        else $error("buffer enable");
    a_standby_idle: assert property (notNormal |-> !slotAActive && !slotBActive)
        else $error("slot outside normal");
    a_read_switch: assert property (swRead |=> regRdata == sw_reg)
        else $error("switch readback");
endmodule

bind osq_sequencer osq_seq_sva u_sva (.clk, .rst, .regWrite, .regRead,
    .regAddr, .regWdata, .regRdata, .intBufEn, .pdsoBufEn, .diodeConnect,
    .slotAActive, .slotBActive, .pulseReq);

/* File: testbench/tb_optical_sample_sequencer.sv */
// Self-checking bench for the sample sequencer
`timescale 1ns/1ps
module tb_optical_sample_sequencer
    import osq_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [7:0]  regAddr;
    logic [15:0] regWdata;
    logic        intPinIn = 1'b0;
    logic        pdsoPinIn = 1'b0;
    logic [3:0]  lag = 4'h0;
    logic [2:0]  ph = 3'h0;
    logic        prevA = 1'b0;
    logic [15:0] regRdata, r;
    logic [26:0] dataA, dataB;
    logic [13:0] adcData;
    logic        intBufEn, pdsoBufEn, slotAActive, slotBActive, pulseReq;
    logic        adcValid, dataAValid, dataBValid;
    osq_diodes_t diodeConnect;
    logic [3:0]  code[2];
    logic [3:0]  cs[5] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h3};
    logic [7:0]  defA[5] = '{8'h10, 8'h12, 8'h4b, 8'h31, 8'h20};
    logic [15:0] defV[5] = '{16'h0, 16'h20, 16'h2612, 16'h100, 16'h0};
    longint      sum[2], acc[2];
    int          cnt[2], nPul[2], nAvg[2], ns[2], av[2];
    int          fail_count = 0, check_count = 0, nRes, nStart, k;
    logic [26:0] expQ[2][$];

    osq_sequencer DUT (.clk, .rst, .regWrite, .regRead, .regAddr, .regWdata,
        .regRdata, .intPinIn, .pdsoPinIn, .intBufEn, .pdsoBufEn,
        .diodeConnect, .slotAActive, .slotBActive, .pulseReq, .adcValid,
        .adcData, .dataA, .dataAValid, .dataB, .dataBValid);
    osq_adc_model ADC (.clk, .lag, .pulseReq, .adcValid, .adcData);

    // ------------------------------------------------------------
    // Clocks, tasks and reference model
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    // status pin always driven, slow tick every 8 cycles
    always @(posedge clk) begin
        ph        <= ph + 3'h1;
        pdsoPinIn <= ph[2];
    end
    task automatic chk_reg(input logic [15:0] got, exp);
        chk_data(27'(got), 27'(exp));
    endtask
    task automatic chk_data(input logic [26:0] got, exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {regWrite, regAddr, regWdata} <= {1'b1, a, d};
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        {regRead, regAddr} <= {1'b1, a};
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask
    task automatic report_and_stop();
        $display("checks %0d fails %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Bounded wait; k returns the cycles spent
    task automatic wait_cnt(ref int v, input int n, input int lim);
        k = 0;
        while (v < n) begin
            @(posedge clk);
            k++;
            if (k > lim) begin
                fail_count++;
                report_and_stop();
            end
        end
    endtask
    task automatic clr();
        for (int s = 0; s < 2; s++) begin
            sum[s] = 0;
            acc[s] = 0;
            cnt[s] = 0;
            ns[s] = 0;
            expQ[s].delete();
        end
        nRes = 0;
    endtask
    function automatic logic [1:0] dec(input logic [3:0] c);
        return c == 4'h1 ? 2'h3 : c == 4'h4 ? 2'h2 : c == 4'h5 ? 2'h1 : 2'h0;
    endfunction
    // Model sums each slot, compared at every output pulse
    always @(posedge clk) begin
        for (int s = 0; s < 2; s++) begin
            if (adcValid && (s == 0 ? slotAActive : slotBActive)) begin
                // sample sum clips at twenty bits
                sum[s] = sum[s] + adcData;
                if (sum[s] > 64'hfffff) sum[s] = 64'hfffff;
                cnt[s]++;
                if (cnt[s] == nPul[s]) begin
                    acc[s] += sum[s];
                    sum[s] = 0;
                    cnt[s] = 0;
                    ns[s]++;
                end
                if (ns[s] == nAvg[s]) begin
                    expQ[s].push_back(acc[s][26:0]);
                    acc[s] = 0;
                    ns[s] = 0;
                end
            end
        end
        if (slotAActive && !prevA) nStart++;
        prevA = slotAActive;
        if (pulseReq) chk_reg(16'(diodeConnect), 16'(dec(code[slotBActive])));
        if (dataAValid) chk_data(dataA, expQ[0].pop_front());
        if (dataBValid) begin
            chk_data(dataB, expQ[1].pop_front());
            nRes++;
        end
    end
    initial begin
        void'($urandom(77816));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wr(8'h20, 16'hffff);
        foreach (defA[i]) begin
            rd(defA[i], r);
            chk_reg(r, defV[i]);
        end
        wr(8'h4f, 16'h0026);
        @(negedge clk);
        chk_reg(16'({pdsoBufEn, intBufEn}), 16'h3);
        wr(8'h4b, 16'h2792);
        for (int i = 0; i < 5; i++) begin
            code[0] = cs[i];
            code[1] = cs[(i + 1) % 5];
            nPul[0] = (i == 4) ? 255 : 1 + $urandom % 3;
            nPul[1] = 1 + $urandom % 3;
            av[0] = $urandom % 3;
            av[1] = $urandom % 3;
            nAvg[0] = 1 << av[0];
            nAvg[1] = 1 << av[1];
            lag <= 4'($urandom % 6);
            wr(8'h10, 16'h1);
            wr(8'h14, 16'({code[1], code[0], 4'h0}));
            rd(8'h14, r);
            chk_reg(r, 16'({code[1], code[0], 4'h0}));
            wr(8'h31, 16'(nPul[0] << 8));
            wr(8'h36, 16'(nPul[1] << 8));
            wr(8'h15, 16'(av[1] << 4 | av[0]));
            wr(8'h12, 16'h1);
            clr();
            wr(8'h10, 16'h2);
            wait_cnt(nRes, 3, 60000);
            wr(8'h10, 16'h0);
        end
        wr(8'h10, 16'h1);
        wr(8'h38, 16'h4000);
        wr(8'h12, 16'hffff);
        wr(8'h31, 16'h0100);
        nPul[0] = 1;
        clr();
        nStart = 0;
        wr(8'h10, 16'h2);
        repeat (300) @(posedge clk);
        chk_reg(16'(nStart), 16'h0);
        intPinIn <= 1'b1;
        wait_cnt(nStart, 1, 60);
        chk_reg(16'(k > 6), 16'h1);
        wr(8'h10, 16'h0);
        report_and_stop();
    end
endmodule
